/* File: rtl/sss_start_seq.sv */
// power-up / wake-up start sequencer with hardware mirroring and boot selection
// assumes synchronous analog ready inputs and memory read data
`timescale 1ns/1ps
`include "sss_defines.svh"

module sss_start_seq
   import sss_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   input  wire logic        powerUpEvt,
   input  wire logic        hwResetEvt,
   input  wire logic        wakeEvt,
   input  wire logic        buckCmpOk,
   input  wire logic        ldoReady,
   input  wire logic        xtalReady,
   input  wire logic        timeoutDisable,
   input  wire logic        mirrorEnable,
   input  wire logic        wordCountWe,
   input  wire logic [15:0] wordCountIn,
   input  wire logic [63:0] appFlag1,
   input  wire logic [63:0] appFlag2,
   input  wire logic [31:0] calFlags,
   input  wire logic [7:0]  customSpiSel,
   input  wire logic [7:0]  wakeOpcodeIn,
   input  wire logic [7:0]  uartTmoUnits,
   input  wire logic        memRdValid,
   input  wire logic [31:0] memRdData,
   input  wire logic        ramWrReady,
   input  wire logic        hostAnswer,
   output logic             bandgapEn,
   output logic             ldoEn,
   output logic             xtalEn,
   output logic             dcdcForce,
   output logic             memRdReq,
   output logic [15:0]      memRdAddr,
   output logic             ramWrValid,
   output logic [31:0]      ramWrData,
   output logic             cpuRun,
   output logic             coldFlag,
   output logic             normalMode,
   output logic             devMode,
   output logic             memFaulty,
   output logic             headerLoad,
   output logic [3:0]       searchStep,
   output logic [1:0]       searchIf,
   output logic [1:0]       spiDiv,
   output logic [7:0]       probePins,
   output logic [17:0]      baudRate,
   output logic             probeStrobe,
   output logic [7:0]       flashWakeOpc,
   output logic             addressZeroRemap,
   output logic             softReset,
   output logic             seqDone
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   sss_state_type               state_r;
   logic [`SSS_CNT_W-1:0]       phaseCnt_r;
   logic [`SSS_CNT_W-1:0]       settleCnt_r;
   logic [`SSS_CNT_W+7:0]       waitCnt_r;
   logic [15:0]                 mirrorWordCount_r;
   logic [15:0]                 reqCnt_r;
   logic [15:0]                 wrCnt_r;
   logic [1:0]                  spiLoop_r;
   logic                        customTried_r;
   logic                        rdBusy_r;
   logic                        fifoValid;
   logic [31:0]                 fifoData;
   logic                        settleOk;
   logic [`SSS_CNT_W+7:0]       stepLimit;
   sss_word_if #(.WIDTH(32))    wordBus ();

   // ---------------------------------------------------------------
   // decoding
   // ---------------------------------------------------------------
   function automatic sss_if_type stepIf(input logic [3:0] s);
      if (s < 4'h2) begin
         return IF_SPIM;
      end else if (s < 4'h6) begin
         return IF_UART;
      end else if (s == 4'h6) begin
         return IF_SPIS;
      end
      return IF_I2C;
   endfunction

   function automatic logic [7:0] stepPins(input logic [3:0] s);
      case (s)
         4'h0:    return 8'h36;
         4'h1:    return 8'h01;
         4'h6:    return 8'h36;
         4'h2, 4'h7: return 8'h01;
         4'h3, 4'h8: return 8'h23;
         4'h4, 4'h9: return 8'h45;
         default: return 8'h67;
      endcase
   endfunction

   function automatic logic [17:0] stepBaud(input logic [3:0] s);
      case (s)
         4'h2, 4'h4: return 18'h0e100;
         4'h3:    return 18'h1c200;
         4'h5:    return 18'h02580;
         default: return 18'h00000;
      endcase
   endfunction

   assign settleOk = ldoReady && xtalReady;
   always_comb begin
      if (stepIf(searchStep) == IF_UART) begin
         stepLimit = ((uartTmoUnits == 8'h00) ? `SSS_UART_DEF_UNITS : uartTmoUnits)
                     * (`SSS_CNT_W+8)'(`SSS_UART_UNIT_CYC);
      end else begin
         stepLimit = (`SSS_CNT_W+8)'(`SSS_STEP_TMO_CYC);
      end
   end

   // ---------------------------------------------------------------
   // retained word count
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mirrorWordCount_r <= '0;
      end else if (clkEn && wordCountWe && coldFlag) begin
         mirrorWordCount_r <= wordCountIn;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r          <= PWR_IDLE;
         coldFlag         <= 1'b1;
         phaseCnt_r       <= '0;
         settleCnt_r      <= '0;
         waitCnt_r        <= '0;
         bandgapEn        <= 1'b0;
         ldoEn            <= 1'b0;
         xtalEn           <= 1'b0;
         dcdcForce        <= 1'b0;
         cpuRun           <= 1'b0;
         normalMode       <= 1'b0;
         devMode          <= 1'b0;
         memFaulty        <= 1'b0;
         headerLoad       <= 1'b0;
         searchStep       <= '0;
         searchIf         <= '0;
         spiDiv           <= '0;
         probePins        <= '0;
         baudRate         <= '0;
         probeStrobe      <= 1'b0;
         flashWakeOpc     <= '0;
         addressZeroRemap <= 1'b0;
         softReset        <= 1'b0;
         seqDone          <= 1'b0;
         spiLoop_r        <= '0;
         customTried_r    <= 1'b0;
      end else if (clkEn) begin
         probeStrobe <= 1'b0;
         headerLoad  <= 1'b0;
         softReset   <= 1'b0;
         phaseCnt_r  <= phaseCnt_r + 1'b1;
         if (powerUpEvt || hwResetEvt) begin
            coldFlag <= 1'b1;
         end
         case (state_r)
            PWR_IDLE: begin
               if (powerUpEvt || hwResetEvt || wakeEvt || !seqDone) begin
                  state_r    <= PWR_BUCK;
                  phaseCnt_r <= '0;
                  seqDone    <= 1'b0;
                  cpuRun     <= 1'b0;
                  bandgapEn  <= 1'b0;
                  ldoEn      <= 1'b0;
                  xtalEn     <= 1'b0;
                  dcdcForce  <= 1'b0;
               end
            end
            PWR_BUCK: begin
               if (buckCmpOk) begin
                  state_r   <= PWR_LDO;
                  bandgapEn <= 1'b1;
                  ldoEn     <= 1'b1;
                  settleCnt_r <= '0;
               end
            end
            PWR_LDO: begin
               settleCnt_r <= settleCnt_r + 1'b1;
               if (ldoReady || (!timeoutDisable &&
                   settleCnt_r >= `SSS_CNT_W'(`SSS_SETTLE_TMO_CYC))) begin
                  state_r     <= PWR_XTAL;
                  xtalEn      <= 1'b1;
                  dcdcForce   <= buckCmpOk;
                  settleCnt_r <= '0;
               end
            end
            PWR_XTAL: begin
               settleCnt_r <= settleCnt_r + 1'b1;
               if (settleOk || (!timeoutDisable &&
                   settleCnt_r >= `SSS_CNT_W'(`SSS_SETTLE_TMO_CYC))) begin
                  state_r <= PWR_HOLD;
               end
            end
            PWR_HOLD: begin
               if (phaseCnt_r >= `SSS_CNT_W'(`SSS_PWR_MIN_CYC)) begin
                  if (coldFlag) begin
                     state_r <= BOOT_FLAGS;
                     cpuRun  <= 1'b1;
                  end else if (mirrorEnable) begin
                     state_r <= MIR_RUN;
                  end else begin
                     state_r <= BOOT_DONE;
                  end
               end
            end
            MIR_RUN: begin
               if (wrCnt_r == mirrorWordCount_r) begin
                  state_r <= BOOT_DONE;
               end
            end
            BOOT_FLAGS: begin
               if (appFlag1 == `SSS_APP_FLAG1 && appFlag2 == `SSS_APP_FLAG2) begin
                  normalMode <= 1'b1;
                  state_r    <= BOOT_NORMAL;
                  headerLoad <= (calFlags[31:16] == `SSS_CAL_VALID);
               end else begin
                  devMode    <= 1'b1;
                  memFaulty  <= (appFlag1 != 64'h0) || (appFlag2 != 64'h0);
                  flashWakeOpc <= (wakeOpcodeIn == 8'h00) ? `SSS_WAKE_OPC_DEF
                                                          : wakeOpcodeIn;
                  customTried_r <= (customSpiSel != `SSS_CUSTOM_SPI);
                  searchStep <= '0;
                  spiLoop_r  <= '0;
                  state_r    <= BOOT_SEARCH;
               end
            end
            BOOT_NORMAL: begin
               addressZeroRemap <= 1'b1;
               softReset        <= 1'b1;
               state_r          <= BOOT_DONE;
            end
            BOOT_SEARCH: begin
               searchIf    <= stepIf(searchStep);
               probePins   <= stepPins(searchStep);
               baudRate    <= stepBaud(searchStep);
               spiDiv      <= customTried_r ? spiLoop_r : 2'h0;
               probeStrobe <= 1'b1;
               waitCnt_r   <= '0;
               state_r     <= BOOT_WAIT;
            end
            BOOT_WAIT: begin
               waitCnt_r <= waitCnt_r + 1'b1;
               if (hostAnswer) begin
                  state_r <= BOOT_DONE;
               end else if (waitCnt_r >= stepLimit) begin
                  state_r <= BOOT_SEARCH;
                  if (!customTried_r) begin
                     customTried_r <= 1'b1;
                     searchStep    <= '0;
                  end else if (searchStep == 4'h6 && spiLoop_r != `SSS_SPI_LOOPS) begin
                     spiLoop_r <= spiLoop_r + 1'b1;
                  end else if (searchStep == `SSS_LAST_STEP) begin
                     state_r <= BOOT_DONE;
                  end else begin
                     searchStep <= searchStep + 1'b1;
                  end
               end
            end
            BOOT_DONE: begin
               seqDone  <= 1'b1;
               cpuRun   <= 1'b1;
               coldFlag <= powerUpEvt || hwResetEvt;
               state_r  <= PWR_IDLE;
            end
            default: state_r <= PWR_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // mirroring dma
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reqCnt_r  <= '0;
         memRdReq  <= 1'b0;
         memRdAddr <= '0;
         rdBusy_r  <= 1'b0;
      end else if (clkEn) begin
         memRdReq <= 1'b0;
         if (state_r != MIR_RUN) begin
            reqCnt_r <= '0;
         end else if (rdBusy_r) begin
            rdBusy_r <= !memRdValid;
         end else if (reqCnt_r != mirrorWordCount_r && wordBus.ready) begin
            memRdReq  <= 1'b1;
            memRdAddr <= reqCnt_r;
            reqCnt_r  <= reqCnt_r + 1'b1;
            rdBusy_r  <= 1'b1;
         end
      end
   end

   assign wordBus.valid = memRdValid && (state_r == MIR_RUN);
   assign wordBus.data  = memRdData;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrCnt_r    <= '0;
         ramWrValid <= 1'b0;
         ramWrData  <= '0;
      end else if (clkEn) begin
         if (state_r != MIR_RUN) begin
            wrCnt_r <= '0;
         end
         if (ramWrValid && ramWrReady) begin
            ramWrValid <= 1'b0;
            wrCnt_r    <= wrCnt_r + 1'b1;
         end else if (!ramWrValid && fifoValid) begin
            ramWrValid <= 1'b1;
            ramWrData  <= fifoData;
         end
      end
   end

   sss_fifo #(.WIDTH(32), .DEPTH(`SSS_FIFO_DEPTH)) wordFifo (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .inWord   (wordBus),
      .outValid (fifoValid),
      .outReady (!ramWrValid),
      .outData  (fifoData)
   );
endmodule

/* File: pkg/sss_defines.svh */
// timing, field and encoding constants for the start sequencer
// assumes a 40 MHz core clock
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

`define SSS_CLK_MHZ            40
`define SSS_PWR_MIN_US         1200
`define SSS_PWR_MIN_CYC        ((`SSS_PWR_MIN_US * `SSS_CLK_MHZ))
`define SSS_SETTLE_TMO_US      500
`define SSS_SETTLE_TMO_CYC     ((`SSS_SETTLE_TMO_US * `SSS_CLK_MHZ))
`define SSS_UART_UNIT_US       4000
`define SSS_UART_UNIT_CYC      ((`SSS_UART_UNIT_US * `SSS_CLK_MHZ))
`define SSS_UART_DEF_UNITS     8'h0f
`define SSS_STEP_TMO_US        1000
`define SSS_STEP_TMO_CYC       ((`SSS_STEP_TMO_US * `SSS_CLK_MHZ))
`define SSS_APP_FLAG1          64'h1234a5a51234a5a5
`define SSS_APP_FLAG2          64'ha5a51234a5a51234
`define SSS_CAL_VALID          16'ha5a5
`define SSS_CUSTOM_SPI         8'haa
`define SSS_WAKE_OPC_DEF       8'hab
`define SSS_LAST_STEP          4'ha
`define SSS_SPI_LOOPS          2'h3
`define SSS_FIFO_DEPTH         4
`define SSS_CNT_W              24

`endif

/* File: pkg/sss_pkg.sv */
// types of the start sequencer
// assumes sss_defines.svh is on the include path
package sss_pkg;
   typedef enum logic [3:0] {
      PWR_IDLE, PWR_BUCK, PWR_LDO, PWR_XTAL, PWR_HOLD,
      MIR_RUN, BOOT_FLAGS, BOOT_NORMAL, BOOT_SEARCH, BOOT_WAIT, BOOT_DONE
   } sss_state_type;

   typedef enum logic [1:0] {
      IF_SPIM, IF_UART, IF_SPIS, IF_I2C
   } sss_if_type;
endpackage

/* File: pkg/sss_word_if.sv */
// carrier for mirrored words between sequencer and fifo
// assumes one clock domain
`timescale 1ns/1ps
interface sss_word_if #(parameter int WIDTH = 32);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src  (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

/* File: rtl/sss_fifo.sv */
// small flop fifo on the mirrored word path
// assumes synchronous inputs and core_clk
`timescale 1ns/1ps
module sss_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             clkEn,
   sss_word_if.sink              inWord,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign inWord.ready = (count_r != (AW+1)'(DEPTH));
   assign outValid     = (count_r != '0);
   assign outData      = mem_r[rdPtr_r];
   assign push         = clkEn && inWord.valid && inWord.ready;
   assign pop          = clkEn && outValid && outReady;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wrPtr_r] <= inWord.data;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: dv/sss_mem_model.sv */
// memory and ram partner of the start sequencer
// assumes core_clk domain, reads answered two cycles after request
`timescale 1ns/1ps
module sss_mem_model (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        memRdReq,
   input  wire logic [15:0] memRdAddr,
   input  wire logic        slowWr,
   output logic             memRdValid,
   output logic [31:0]      memRdData,
   output logic             ramWrReady
);
   logic        reqStage_r;
   logic [15:0] addrStage_r;
   logic [1:0]  phase_r;
   // ----------------------------------------
   // read return, data inverted when idle
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reqStage_r  <= 1'b0;
         addrStage_r <= 16'h0000;
         memRdValid  <= 1'b0;
         memRdData   <= 32'h00000000;
      end else begin
         reqStage_r  <= memRdReq;
         addrStage_r <= memRdAddr;
         memRdValid  <= reqStage_r;
         memRdData   <= reqStage_r ? {~addrStage_r, addrStage_r} : ~memRdData;
      end
   end
   // ----------------------------------------
   // ram write acceptance, stalls when slow
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_r    <= 2'h0;
         ramWrReady <= 1'b0;
      end else begin
         phase_r    <= phase_r + 2'h1;
         ramWrReady <= !slowWr || (phase_r == 2'h3);
      end
   end
endmodule

/* File: dv/sss_start_seq_props.sv */
// assertions on the start sequencer ports
// assumes one clock domain and sss_defines.svh on the include path
`timescale 1ns/1ps
`include "sss_defines.svh"
module sss_start_seq_props (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        wakeEvt,
   input wire logic        buckCmpOk,
   input wire logic        ldoReady,
   input wire logic        timeoutDisable,
   input wire logic        mirrorEnable,
   input wire logic [63:0] appFlag1,
   input wire logic [63:0] appFlag2,
   input wire logic [31:0] calFlags,
   input wire logic        bandgapEn,
   input wire logic        ldoEn,
   input wire logic        xtalEn,
   input wire logic        ramWrValid,
   input wire logic        ramWrReady,
   input wire logic        coldFlag,
   input wire logic        normalMode,
   input wire logic        devMode,
   input wire logic        headerLoad,
   input wire logic        addressZeroRemap,
   input wire logic        softReset,
   input wire logic        seqDone
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [16:0] pwrCnt_r;
   logic [15:0] setCnt_r;
   // ----------------------------------------
   // cycle counters
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) pwrCnt_r <= 17'h00000;
      else if (wakeEvt) pwrCnt_r <= 17'h00000;
      else if (pwrCnt_r != 17'h1ffff) pwrCnt_r <= pwrCnt_r + 17'h00001;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) setCnt_r <= 16'h0000;
      else if (!(ldoEn && !xtalEn)) setCnt_r <= 16'h0000;
      else if (setCnt_r != 16'hffff) setCnt_r <= setCnt_r + 16'h0001;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_buck_first: assert property ($rose(bandgapEn) |-> $past(buckCmpOk))
      else $error("bandgap enabled without buck ok");
   a_xtal_after_ldo: assert property ($rose(xtalEn) |-> ldoEn && bandgapEn)
      else $error("crystal started before regulators");
   a_settle_limit: assert property (!timeoutDisable && ldoEn && !xtalEn |-> setCnt_r <= 16'h4e2a)
      else $error("settle wait exceeded timeout");
   a_no_tmo_wait: assert property (timeoutDisable && $rose(xtalEn) |-> $past(ldoReady))
      else $error("timeout taken while disabled");
   a_power_min: assert property ($rose(seqDone) |-> pwrCnt_r >= 17'h0bb80)
      else $error("sequence done too early");
   a_boot_cold: assert property ($rose(normalMode || devMode) |-> coldFlag)
      else $error("boot mode entered on warm start");
   a_hw_mirror: assert property (ramWrValid |-> !coldFlag && mirrorEnable && xtalEn)
      else $error("mirror write outside warm mirroring");
   a_normal_flags: assert property ($rose(normalMode) |->
      appFlag1 == `SSS_APP_FLAG1 && appFlag2 == `SSS_APP_FLAG2)
      else $error("normal mode without both flags");
   a_header_cal: assert property (headerLoad |-> calFlags[31:16] == `SSS_CAL_VALID)
      else $error("header load with invalid calibration");
   a_remap_reset: assert property (softReset |-> addressZeroRemap ##1 !softReset)
      else $error("soft reset without remap");
   c_normal: cover property ($rose(normalMode));
   c_stall: cover property (ramWrValid && !ramWrReady);
   c_sw_reset: cover property (softReset);
   c_tmo: cover property ($rose(xtalEn) && !ldoReady);
endmodule
bind sss_start_seq sss_start_seq_props u_props (.core_clk, .reset_n, .wakeEvt, .buckCmpOk,
   .ldoReady, .timeoutDisable, .mirrorEnable, .appFlag1, .appFlag2, .calFlags, .bandgapEn,
   .ldoEn, .xtalEn, .ramWrValid, .ramWrReady, .coldFlag, .normalMode, .devMode, .headerLoad,
   .addressZeroRemap, .softReset, .seqDone);

/* File: dv/sss_start_seq_tb.sv */
// self-checking bench of the start sequencer
// assumes 40 MHz core_clk and the memory partner model
`timescale 1ns/1ps
module sss_start_seq_tb;
   logic        core_clk, reset_n, clkEn, powerUpEvt, hwResetEvt, wakeEvt, buckCmpOk;
   logic        ldoReady, xtalReady, timeoutDisable, mirrorEnable, wordCountWe, hostAnswer;
   logic        slowWr, memRdValid, ramWrReady, memRdReq, ramWrValid, bandgapEn, ldoEn, xtalEn;
   logic        coldFlag, normalMode, devMode, headerLoad, addressZeroRemap, softReset, seqDone;
   logic        cpuRun, dcdcForce, memFaulty, probeStrobe;
   logic [15:0] wordCountIn, memRdAddr;
   logic [63:0] appFlag1, appFlag2;
   logic [31:0] calFlags, memRdData, ramWrData;
   logic [7:0]  customSpiSel, wakeOpcodeIn, uartTmoUnits;
   int          err_total, cmp_count, wrSeen, hdrSeen, cyc, relCyc;
   // ----------------------------------------
   // clock, instances, monitors
   // ----------------------------------------
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;
   sss_start_seq dut_u (.core_clk, .reset_n, .clkEn, .powerUpEvt, .hwResetEvt, .wakeEvt,
      .buckCmpOk, .ldoReady, .xtalReady, .timeoutDisable, .mirrorEnable, .wordCountWe,
      .wordCountIn, .appFlag1, .appFlag2, .calFlags, .customSpiSel, .wakeOpcodeIn,
      .uartTmoUnits, .memRdValid, .memRdData, .ramWrReady, .hostAnswer, .bandgapEn, .ldoEn,
      .xtalEn, .dcdcForce, .memRdReq, .memRdAddr, .ramWrValid, .ramWrData, .cpuRun,
      .coldFlag, .normalMode, .devMode, .memFaulty, .headerLoad, .searchStep(),
      .searchIf(), .spiDiv(), .probePins(), .baudRate(), .probeStrobe, .flashWakeOpc(),
      .addressZeroRemap, .softReset, .seqDone);
   sss_mem_model mem_u (.core_clk, .reset_n, .memRdReq, .memRdAddr, .slowWr, .memRdValid,
      .memRdData, .ramWrReady);
   always @(posedge core_clk) begin
      cyc++;
      if (reset_n && headerLoad === 1'b1) hdrSeen++;
      if (reset_n && ramWrValid === 1'b1 && ramWrReady === 1'b1) begin
         chk(ramWrData === {~wrSeen[15:0], wrSeen[15:0]}, "mirror word");
         wrSeen++;
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         $display("ERROR %0t %s", $time, msg);
         err_total++;
      end
   endtask
   function automatic logic sigOf(input int k);
      case (k)
         0: return xtalEn;
         1: return headerLoad;
         2: return softReset;
         3: return seqDone;
         4: return ldoEn;
         5: return wrSeen >= 5;
         default: return 1'b0;
      endcase
   endfunction
   task automatic waitHi(input int k, input int lim, output int n);
      n = 0;
      while (sigOf(k) !== 1'b1) begin
         tick();
         n++;
         if (n > lim) begin
            $display("ERROR %0t wait %0d timed out", $time, k);
            err_total++;
            print_verdict();
         end
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_cold;
      int n;
      repeat (100) tick();
      chk(bandgapEn === 1'b0, "bandgap before buck ok");
      buckCmpOk = 1'b1;
      waitHi(4, 200, n);
      chk(bandgapEn === 1'b1, "bandgap with ldo");
      waitHi(0, 21000, n);
      chk(n >= 19990 && normalMode === 1'b0, "settle timeout");
      chk(dcdcForce === 1'b1, "dcdc mode forced with crystal start");
      ldoReady = 1'b1;
      xtalReady = 1'b1;
      wordCountWe = 1'b1;
      wordCountIn = 16'h0005;
      hostAnswer = 1'b1;
      tick();
      wordCountWe = 1'b0;
      hostAnswer = 1'b0;
      clkEn = 1'b0;
      repeat (8) tick();
      clkEn = 1'b1;
      waitHi(1, 62000, n);
      chk(cyc - relCyc >= 48000 && cyc - relCyc <= 60100, "power phase length");
      chk(normalMode === 1'b1 && devMode === 1'b0, "normal mode");
      chk(memFaulty === 1'b0 && probeStrobe === 1'b0, "no search in normal mode");
      waitHi(2, 5, n);
      chk(addressZeroRemap === 1'b1, "remap before soft reset");
      waitHi(3, 50, n);
      tick();
      chk(coldFlag === 1'b0 && wrSeen == 0, "cold flag cleared");
      chk(cpuRun === 1'b1, "cpu released after boot");
   endtask
   task automatic t_wake;
      int n;
      ldoReady = 1'b0;
      xtalReady = 1'b0;
      timeoutDisable = 1'b1;
      mirrorEnable = 1'b1;
      slowWr = 1'b1;
      wakeEvt = 1'b1;
      wordCountWe = 1'b1;
      wordCountIn = 16'h0009;
      tick();
      wakeEvt = 1'b0;
      wordCountWe = 1'b0;
      waitHi(4, 200, n);
      chk(xtalEn === 1'b0 && cpuRun === 1'b0, "analog restart on wake");
      repeat (25000) tick();
      chk(xtalEn === 1'b0, "no settle timeout");
      ldoReady = 1'b1;
      xtalReady = 1'b1;
      waitHi(5, 60000, n);
      chk(cpuRun === 1'b0, "cpu held during mirroring");
      repeat (50) tick();
      chk(wrSeen == 5, "mirror word count");
      chk(hdrSeen == 1 && coldFlag === 1'b0, "no boot on wake");
      chk(seqDone === 1'b1, "wake sequence done");
      hwResetEvt = 1'b1;
      tick();
      hwResetEvt = 1'b0;
      chk(coldFlag === 1'b1 && seqDone === 1'b0, "restart on hardware reset");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {err_total, cmp_count, wrSeen, hdrSeen, cyc} = '0;
      {reset_n, clkEn, powerUpEvt, hwResetEvt, wakeEvt, buckCmpOk} = '0;
      {ldoReady, xtalReady, timeoutDisable, mirrorEnable, wordCountWe, hostAnswer} = '0;
      slowWr = 1'b0;
      clkEn = 1'b1;
      wordCountIn = 16'h0000;
      appFlag1 = 64'h1234a5a51234a5a5;
      appFlag2 = 64'ha5a51234a5a51234;
      calFlags = 32'ha5a50000;
      customSpiSel = 8'h00;
      wakeOpcodeIn = 8'h00;
      uartTmoUnits = 8'h00;
      repeat (10) tick();
      chk(coldFlag === 1'b1 && seqDone === 1'b0 && bandgapEn === 1'b0, "reset values");
      repeat (10) tick();
      reset_n = 1'b1;
      relCyc = cyc;
      t_cold();
      t_wake();
      print_verdict();
   end
endmodule
